//--- include/rip_pkg.sv
/*
  Constants shared by the real-time clock two-wire slave port.
  Assumes a single 200 MHz system clock domain.
*/
package rip_pkg;
  localparam logic [6:0] RIP_SLAVE_ADDR = 7'h68;
  localparam logic [7:0] RIP_ADDR_RST = 8'h00;
  localparam logic [3:0] RIP_BIT_LAST = 4'h7;
  localparam logic [3:0] RIP_BIT_ACK = 4'h8;
  localparam int RIP_CLK_MHZ = 200;
  localparam int RIP_FIFO_DEPTH = 16;
  typedef enum logic [2:0] {
    RIP_IDLE,
    RIP_ADDR,
    RIP_REG,
    RIP_WDATA,
    RIP_RDATA,
    RIP_PASS
  } rip_state_t;
endpackage : rip_pkg

//--- core/rip_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rip_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Full and empty rely on a wrap bit, so only powers of two of two or more work.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("rip_fifo DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // Full and empty come from the extra pointer bit.
  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer update.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  // Storage is written without reset; only the pointers matter.
  always_ff @(posedge clk_sys) begin
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end
endmodule : rip_fifo
`default_nettype wire

//--- core/rip_slave.sv
/*
  Two-wire serial slave port giving an outside master access to the
  register space. Written bytes leave through a FIFO as address/data
  pairs; read data comes from a register-space read port.
  Assumes scl and sda arrive asynchronously and the register space
  answers reads combinationally from rd_addr.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Start is sda falling with scl high; stop is sda rising with scl high.
// - A repeated start begins a new transfer exactly like a start.
// - Driven data changes only while scl is low.
// - Incoming bits are captured on the rising scl edge.
// - Outgoing bits are placed after the falling scl edge.
// - The device never holds scl low.
// - Ninth bit is acknowledge by receiver: 0 ack, 1 nack.
// - Written bytes are eight bits, msb first, acknowledged by device; this port nacks them while its FIFO is full.
// - Reads send eight bits msb first; nack ends and releases sda.
// - First byte after start is seven address bits plus read/write bit.
// - Only address bytes D0h and D1h are answered.
// - A mismatched address leaves the device passive until next start.
// - Byte after write address loads the address counter.
// - Any number of data bytes may follow in one write.
// - Reads start at the current address counter.
// - Dummy write then repeated start reads from the chosen register.
// - Reading continues while the master acknowledges.
module rip_slave
  import rip_pkg::*;
#(
  parameter int FIFO_DEPTH = rip_pkg::RIP_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic rd_strobe,
  output logic busy
);
  import rip_pkg::*;

  // The buffer counts with a wrap bit, so it needs a power of two of two or more.
  if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_bad_depth
    $error("rip_slave FIFO_DEPTH must be a power of two, at least 2");
  end

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  rip_state_t state_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] cnt_q;
  logic drive_q;
  logic ack_phase_q;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [15:0] fifo_out_data;
  logic byte_done;
  logic [7:0] rx_byte;
  logic rd_strobe_q;
  logic busy_q;
  logic rd_next;

  // Two-stage synchronisers; the first stage feeds only the second.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Edge and condition decode on synchronised lines.
  assign scl_rise = scl_sync_q[1] && !scl_prev_q;
  assign scl_fall = !scl_sync_q[1] && scl_prev_q;
  assign start_det = scl_sync_q[1] && scl_prev_q && sda_prev_q && !sda_sync_q[1];
  assign stop_det = scl_sync_q[1] && scl_prev_q && !sda_prev_q && sda_sync_q[1];
  assign rx_byte = {shift_q[6:0], sda_sync_q[1]};
  assign byte_done = scl_rise && (bit_q == RIP_BIT_LAST);
  // A low ninth bit in a read asks for another byte. The address acknowledge
  // counts too, since the state has already turned to read by then.
  assign rd_next = scl_rise && bit_q == RIP_BIT_ACK && state_q == RIP_RDATA && !sda_sync_q[1];

  // The clock line is only ever observed, never pulled low.
  assign scl_o = 1'b0;
  assign scl_oe = 1'b0;

  // Bit counter: 0..7 data bits, 8 is the acknowledge slot.
  always_ff @(posedge clk_sys) begin
    if (rst || start_det || stop_det) begin
      bit_q <= 4'h0;
    end else if (scl_rise) begin
      bit_q <= (bit_q == RIP_BIT_ACK) ? 4'h0 : bit_q + 4'h1;
    end
  end

  // Receive shifter, msb first, sampled on rising scl.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shift_q <= 8'h00;
    end else if (scl_rise && bit_q != RIP_BIT_ACK) begin
      shift_q <= rx_byte;
    end
  end

  // Protocol state machine.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= RIP_IDLE;
    end else if (start_det) begin
      state_q <= RIP_ADDR;
    end else if (stop_det) begin
      state_q <= RIP_IDLE;
    end else if (scl_rise) begin
      unique case (state_q)
        RIP_IDLE: state_q <= RIP_IDLE;
        RIP_PASS: state_q <= RIP_PASS;
        RIP_ADDR: begin
          if (byte_done) begin
            if (rx_byte[7:1] != RIP_SLAVE_ADDR) state_q <= RIP_PASS;
            else if (rx_byte[0]) state_q <= RIP_RDATA;
            else state_q <= RIP_REG;
          end
        end
        RIP_REG: begin
          if (byte_done) state_q <= RIP_WDATA;
        end
        RIP_WDATA: state_q <= RIP_WDATA;
        RIP_RDATA: begin
          // A nack from the master parks the port until stop or start.
          if (bit_q == RIP_BIT_ACK && sda_sync_q[1]) state_q <= RIP_PASS;
        end
      endcase
    end
  end

  // Address counter: loaded by the register byte, stepped per data byte taken into the FIFO or fetched for a read.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= RIP_ADDR_RST;
    end else if (byte_done && state_q == RIP_REG) begin
      cnt_q <= rx_byte;
    end else if (byte_done && state_q == RIP_WDATA && fifo_in_ready) begin
      cnt_q <= cnt_q + 8'h01;
    end else if (rd_next) begin
      // Stepping as each next byte is fetched leaves the counter just past the
      // last byte sent; the final nack fetches nothing, so it does not step.
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Written bytes go into the FIFO; a full FIFO makes the device nack.
  assign fifo_in_valid = byte_done && state_q == RIP_WDATA;

  // Acknowledge flag records whether the device should pull low in slot 9.
  always_ff @(posedge clk_sys) begin
    if (rst || start_det || stop_det) begin
      ack_phase_q <= 1'b0;
    end else if (byte_done) begin
      unique case (state_q)
        RIP_ADDR: ack_phase_q <= rx_byte[7:1] == RIP_SLAVE_ADDR;
        RIP_REG: ack_phase_q <= 1'b1;
        RIP_WDATA: ack_phase_q <= fifo_in_ready;
        default: ack_phase_q <= 1'b0;
      endcase
    end else if (scl_rise && bit_q == RIP_BIT_ACK) begin
      ack_phase_q <= 1'b0;
    end
  end

  // Read data is latched at the start of each byte so it stays stable.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_q <= 8'h00;
      rd_strobe_q <= 1'b0;
    end else begin
      rd_strobe_q <= 1'b0;
      if (rd_next) begin
        tx_q <= rd_data;
        rd_strobe_q <= 1'b1;
      end else if (scl_rise && state_q == RIP_RDATA && bit_q != RIP_BIT_ACK) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // Drive is updated only on falling scl so sda never moves while scl is high.
  always_ff @(posedge clk_sys) begin
    if (rst || stop_det || start_det) begin
      drive_q <= 1'b0;
    end else if (scl_fall) begin
      if (bit_q == RIP_BIT_ACK) begin
        drive_q <= ack_phase_q;
      end else if (state_q == RIP_RDATA) begin
        drive_q <= !tx_q[7];
      end else begin
        drive_q <= 1'b0;
      end
    end
  end

  // Busy is high from a start to the stop, and drops once a wrong address or a read nack parks the port.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= state_q != RIP_IDLE && state_q != RIP_PASS;
    end
  end

  // Open drain: only ever pull low.
  assign sda_o = 1'b0;
  assign sda_oe = drive_q;
  assign rd_addr = cnt_q;
  assign rd_strobe = rd_strobe_q;
  assign busy = busy_q;

  // Buffer decouples bus timing from register-space back-pressure.
  rip_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) rip_fifo_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({cnt_q, rx_byte}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out_data)
  );
  assign wr_addr = fifo_out_data[15:8];
  assign wr_data = fifo_out_data[7:0];

  // Protocol checks on what this port drives and on its state, counters and read latch.

  AST_NO_SCL_DRIVE: assert property (@(posedge clk_sys) disable iff (rst) !scl_oe)
    else $error("scl driven");
  AST_SDA_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    (scl_sync_q[1] && scl_prev_q && !start_det && !stop_det) |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  AST_STOP_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
    stop_det |=> (state_q == RIP_IDLE && !sda_oe))
    else $error("stop did not idle");
  AST_START_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
    start_det |=> (state_q == RIP_ADDR && bit_q == 4'h0))
    else $error("start not seen");
  AST_PASSIVE: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == RIP_PASS |-> !drive_q)
    else $error("passive port drives");
  AST_REG_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
    (byte_done && state_q == RIP_REG) |=> cnt_q == $past(rx_byte))
    else $error("counter not loaded");
  AST_CNT_STEP: assert property (@(posedge clk_sys) disable iff (rst)
    (byte_done && state_q == RIP_WDATA && fifo_in_ready) |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter not stepped");
  AST_BAD_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
    (byte_done && state_q == RIP_ADDR && rx_byte[7:1] != RIP_SLAVE_ADDR && !start_det && !stop_det)
    |=> state_q == RIP_PASS)
    else $error("wrong address accepted");
  AST_RD_STEP: assert property (@(posedge clk_sys) disable iff (rst)
    rd_next |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("read counter not stepped");
  AST_RD_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
    rd_next |=> (rd_strobe_q && tx_q == $past(rd_data)))
    else $error("read byte not latched");
  AST_RD_NACK: assert property (@(posedge clk_sys) disable iff (rst)
    (scl_rise && bit_q == RIP_BIT_ACK && state_q == RIP_RDATA && sda_sync_q[1])
    |=> (state_q == RIP_PASS && $stable(cnt_q)))
    else $error("read nack not honoured");
endmodule : rip_slave
`default_nettype wire

//--- testbench/rip_master_model.sv
/*
  Behavioural two-wire bus master that drives the slave port.
  Assumes the bench resolves sda from both enables with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module rip_master_model (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // The clock is pushed both ways and rests high between frames.
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // Data moves mid-low and is read mid-high, leaving margin on both sides.
  task automatic bit_io(input logic b, output logic r);
    #20 sda_oe = ~b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
  endtask : bit_io

  // Serves for a first start and a repeated one alike.
  task automatic start();
    sda_oe = 1'b0;
    #20 scl = 1'b1;
    #20 sda_oe = 1'b1;
    #20 scl = 1'b0;
  endtask : start

  task automatic stop();
    #20 sda_oe = 1'b1;
    #20 scl = 1'b1;
    #20 sda_oe = 1'b0;
    #20;
  endtask : stop

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put_byte

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : get_byte
endmodule : rip_master_model
`default_nettype wire

//--- testbench/rip_slave_bench.sv
/*
  Self-checking bench for the two-wire slave port.
  Assumes the master model sits on the bus and the read space is modelled here.
*/
`timescale 1ns/1ps
`default_nettype none
module rip_slave_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wr_ready = 1'b1;
  logic [7:0] rd_data, rd_addr, wr_addr, wr_data;
  logic scl_m, m_oe, scl_o, scl_oe, sda_o, sda_oe, wr_valid, busy, rd_strobe;
  int strobes = 0;
  wire scl, sda;
  logic [15:0] got_q[$];
  int failures = 0;
  int checks_done = 0;

  always #2.5 clk_sys = ~clk_sys;

  // Open-drain resolution: anyone pulling low wins, else the pull-up.
  assign sda = (m_oe | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
  assign scl = (scl_oe && !scl_o) ? 1'b0 : scl_m;
  assign rd_data = rd_addr ^ 8'h5A;

  rip_slave #(.FIFO_DEPTH(16)) rip_slave_i (
    .clk_sys(clk_sys), .rst(rst), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_strobe(rd_strobe), .busy(busy)
  );
  rip_master_model rip_master_model_i (.scl(scl_m), .sda_oe(m_oe), .sda(sda));

  // Collects every pair the sink takes; also watches that scl is never held.
  always @(posedge clk_sys) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) got_q.push_back({wr_addr, wr_data});
    if (rd_strobe === 1'b1) strobes++;
    if (rst === 1'b0 && scl_oe !== 1'b0) chk({15'h0, scl_oe}, 16'h0);
  end

  task automatic test_done();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic [7:0] d, input logic e);
    logic a;
    rip_master_model_i.put_byte(d, a);
    chk({15'h0, a}, {15'h0, e});
  endtask : wb

  task automatic rb(input logic last, input logic [7:0] e);
    logic [7:0] d;
    rip_master_model_i.get_byte(last, d);
    chk({8'h0, d}, {8'h0, e});
  endtask : rb

  // Bounded wait for the sink to have seen n pairs.
  task automatic wait_q(input int n);
    int k = 0;
    while (got_q.size() < n && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 400) begin
      failures++;
      test_done();
    end
  endtask : wait_q

  task automatic t_write();
    got_q.delete();
    rip_master_model_i.start();
    wb(8'hD0, 1'b1);
    wb(8'h10, 1'b1);
    for (int i = 0; i < 3; i++) wb(8'hC0 + 8'(i), 1'b1);
    rip_master_model_i.stop();
    wait_q(3);
    for (int i = 0; i < 3; i++) chk(got_q[i], {8'h10 + 8'(i), 8'hC0 + 8'(i)});
    chk({8'h0, rd_addr}, 16'h0013);
    chk({15'h0, busy}, 16'h0);
  endtask : t_write

  task automatic t_rand();
    strobes = 0;
    rip_master_model_i.start();
    wb(8'hD0, 1'b1);
    wb(8'h20, 1'b1);
    rip_master_model_i.start();
    wb(8'hD1, 1'b1);
    rb(1'b0, 8'h20 ^ 8'h5A);
    rb(1'b0, 8'h21 ^ 8'h5A);
    rb(1'b1, 8'h22 ^ 8'h5A);
    rip_master_model_i.stop();
    chk({8'h0, rd_addr}, 16'h0023);
    chk({15'h0, sda_oe}, 16'h0);
    chk(16'(strobes), 16'h0003);
  endtask : t_rand

  task automatic t_cur();
    strobes = 0;
    rip_master_model_i.start();
    wb(8'hD1, 1'b1);
    rb(1'b1, 8'h23 ^ 8'h5A);
    rip_master_model_i.stop();
    chk(16'(strobes), 16'h0001);
  endtask : t_cur

  // Foreign addresses must leave the port silent until the next start.
  task automatic t_bad();
    got_q.delete();
    strobes = 0;
    rip_master_model_i.start();
    wb(8'hD2, 1'b0);
    wb(8'h00, 1'b0);
    rip_master_model_i.start();
    wb(8'hA1, 1'b0);
    rip_master_model_i.stop();
    chk({8'h0, rd_addr}, 16'h0024);
    chk(16'(got_q.size()), 16'h0);
    chk(16'(strobes), 16'h0000);
  endtask : t_bad

  // Stalled sink: sixteen bytes fit, the seventeenth is refused.
  task automatic t_full();
    @(negedge clk_sys) wr_ready = 1'b0;
    got_q.delete();
    rip_master_model_i.start();
    wb(8'hD0, 1'b1);
    wb(8'h40, 1'b1);
    for (int i = 0; i < 16; i++) wb(8'h80 + 8'(i), 1'b1);
    wb(8'hEE, 1'b0);
    rip_master_model_i.stop();
    @(negedge clk_sys) wr_ready = 1'b1;
    wait_q(16);
    repeat (4) @(posedge clk_sys);
    chk(16'(got_q.size()), 16'h0010);
    for (int i = 0; i < 16; i++) chk(got_q[i], {8'h40 + 8'(i), 8'h80 + 8'(i)});
    chk({8'h0, rd_addr}, 16'h0050);
  endtask : t_full

  // Watchdog cutting a hang short.
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    test_done();
  end

  // Main sequence.
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    t_write();
    t_rand();
    t_cur();
    t_bad();
    t_full();
    test_done();
  end
endmodule : rip_slave_bench
`default_nettype wire
